// [rtl/rxfd_regs.vh]
// constants shared by the receive framer and 10b/8b decoder
`ifndef RXFD_REGS_VH
`define RXFD_REGS_VH

// ----------------------------------------
// three-level select codes after resolving
// ----------------------------------------
`define RXFD_TRI_LOW 2'h0
`define RXFD_TRI_MID 2'h1
`define RXFD_TRI_HIGH 2'h2
`define RXFD_TRI_OPEN 2'h3

// ----------------------------------------
// framing patterns, first bit received in bit 9
// ----------------------------------------
`define RXFD_K285_NEG 10'h0FA
`define RXFD_K285_POS 10'h305
`define RXFD_COMMA_POS 8'h3E
`define RXFD_COMMA_NEG 8'hC1

// ----------------------------------------
// framer timing counts, in characters or bits
// ----------------------------------------
`define RXFD_CHAR_BITS 4'hA
`define RXFD_LL_MAX_STEP 4'h2
`define RXFD_LL_LAT_CHAR 4'h9
`define RXFD_LL_LAT_HALF 4'hE
`define RXFD_MB_MAX_AGE 3'h4
`define RXFD_ALT_NEEDED 3'h4

// ----------------------------------------
// receive status codes
// ----------------------------------------
`define RXFD_ST_DATA 3'h0
`define RXFD_ST_SPECIAL 3'h1
`define RXFD_ST_FRAMING 3'h2
`define RXFD_ST_RESYNC 3'h3
`define RXFD_ST_DISP_ERR 3'h5
`define RXFD_ST_INVALID 3'h6

`endif

// [rtl/rxfd_pin_sync.v]
// two-flop synchroniser for asynchronous select pins
`timescale 1ns/100ps
module rxfd_pin_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins and synchronised copies
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk) begin
        if (rst) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= pin_in[g];
          stable <= meta;
        end
      end
      assign pin_out[g] = stable;
    end
  endgenerate

endmodule // rxfd_pin_sync

// [rtl/rxfd_decoder.v]
// 10b/8b decoder with status, odd parity and raw bypass
`timescale 1ns/100ps
`include "rxfd_regs.vh"
module rxfd_decoder (
  // clock and reset
  input wire clk,
  input wire rst,
  // framed character in
  input wire in_valid,
  input wire [9:0] in_char,
  input wire in_framing,
  input wire in_resync,
  input wire [1:0] dec_mode,
  // output register
  output reg out_valid,
  output reg [9:0] out_data,
  output reg [2:0] out_status,
  output reg out_parity
);

  // ----------------------------------------
  // code tables
  // ----------------------------------------
  function [5:0] dec6;
    input [5:0] c;
    case (c)
      6'h27, 6'h18: dec6 = 6'h00;
      6'h1D, 6'h22: dec6 = 6'h01;
      6'h2D, 6'h12: dec6 = 6'h02;
      6'h31: dec6 = 6'h03;
      6'h35, 6'h0A: dec6 = 6'h04;
      6'h29: dec6 = 6'h05;
      6'h19: dec6 = 6'h06;
      6'h38, 6'h07: dec6 = 6'h07;
      6'h39, 6'h06: dec6 = 6'h08;
      6'h25: dec6 = 6'h09;
      6'h15: dec6 = 6'h0A;
      6'h34: dec6 = 6'h0B;
      6'h0D: dec6 = 6'h0C;
      6'h2C: dec6 = 6'h0D;
      6'h1C: dec6 = 6'h0E;
      6'h17, 6'h28: dec6 = 6'h0F;
      6'h1B, 6'h24: dec6 = 6'h10;
      6'h23: dec6 = 6'h11;
      6'h13: dec6 = 6'h12;
      6'h32: dec6 = 6'h13;
      6'h0B: dec6 = 6'h14;
      6'h2A: dec6 = 6'h15;
      6'h1A: dec6 = 6'h16;
      6'h3A, 6'h05: dec6 = 6'h17;
      6'h33, 6'h0C: dec6 = 6'h18;
      6'h26: dec6 = 6'h19;
      6'h16: dec6 = 6'h1A;
      6'h36, 6'h09: dec6 = 6'h1B;
      6'h0E: dec6 = 6'h1C;
      6'h2E, 6'h11: dec6 = 6'h1D;
      6'h1E, 6'h21: dec6 = 6'h1E;
      6'h2B, 6'h14: dec6 = 6'h1F;
      default: dec6 = 6'h20;
    endcase
  endfunction

  function [3:0] dec4;
    input [3:0] c;
    case (c)
      4'hB, 4'h4: dec4 = 4'h0;
      4'h9: dec4 = 4'h1;
      4'h5: dec4 = 4'h2;
      4'hC, 4'h3: dec4 = 4'h3;
      4'hD, 4'h2: dec4 = 4'h4;
      4'hA: dec4 = 4'h5;
      4'h6: dec4 = 4'h6;
      4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'h7;
      default: dec4 = 4'h8;
    endcase
  endfunction

  function [2:0] ones;
    input [5:0] v;
    integer i;
    begin
      ones = 3'h0;
      for (i = 0; i < 6; i = i + 1)
        ones = ones + {2'b00, v[i]};
    end
  endfunction

  // ----------------------------------------
  // combinational decode
  // ----------------------------------------
  reg rd;
  reg next_rd;
  reg is_k28;
  reg is_k7;
  reg bad;
  reg disp_err;
  reg rd_mid;
  reg [5:0] r6;
  reg [3:0] r4;
  reg [2:0] n6;
  reg [2:0] n4;
  reg [7:0] byte_val;
  reg [9:0] next_data;
  reg [2:0] next_status;

  always @* begin
    is_k28 = (in_char[9:4] == 6'h0F) || (in_char[9:4] == 6'h30);
    // k28 in positive form inverts its trailing nibble
    r4 = dec4((in_char[9:4] == 6'h30) ? ~in_char[3:0] : in_char[3:0]);
    r6 = dec6(in_char[9:4]);
    is_k7 = ((in_char[3:0] == 4'h7) || (in_char[3:0] == 4'h8)) &&
            (r6[4:0] == 5'h17 || r6[4:0] == 5'h1B ||
             r6[4:0] == 5'h1D || r6[4:0] == 5'h1E) && !r6[5];
    n6 = ones(in_char[9:4]);
    n4 = ones({2'b00, in_char[3:0]});
    bad = (r6[5] && !is_k28) || r4[3] ||
          (n6 < 3'h2) || (n6 > 3'h4) || (n4 < 3'h1) || (n4 > 3'h3);
    rd_mid = (n6 != 3'h3) ? ~rd : rd;
    disp_err = (n6 == 3'h4 && rd) || (n6 == 3'h2 && !rd) ||
               (n4 == 3'h3 && rd_mid) || (n4 == 3'h1 && !rd_mid);
    next_rd = (n4 != 3'h2) ? ~rd_mid : rd_mid;
    byte_val = {r4[2:0], is_k28 ? 5'h1C : r6[4:0]};
    next_status = `RXFD_ST_DATA;
    if (dec_mode == `RXFD_TRI_LOW) begin
      next_data = in_char;
    end else begin
      if ((is_k28 || is_k7) && dec_mode == `RXFD_TRI_HIGH)
        next_data = {3'b000, byte_val[7:5], byte_val[3:0]};
      else
        next_data = {2'b00, byte_val};
      if (in_resync)
        next_status = `RXFD_ST_RESYNC;
      else if (bad)
        next_status = `RXFD_ST_INVALID;
      else if (disp_err)
        next_status = `RXFD_ST_DISP_ERR;
      else if (in_framing)
        next_status = `RXFD_ST_FRAMING;
      else if (is_k28 || is_k7)
        next_status = `RXFD_ST_SPECIAL;
    end
  end

  // ----------------------------------------
  // output register
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      rd <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 10'h000;
      out_status <= `RXFD_ST_DATA;
      out_parity <= 1'b1;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        if (dec_mode != `RXFD_TRI_LOW)
          rd <= next_rd;
        out_data <= next_data;
        out_status <= next_status;
        out_parity <= ~^next_data;
      end
    end
  end

endmodule // rxfd_decoder

// [rtl/rxfd_top.v]
// receive character framer with 10b/8b decoder behind it
//
// Functional notes
// - with framing on, search for the pattern at all ten bit offsets.
// - select at mid matches eight-bit comma of either polarity.
// - select high matches full ten-bit K28.5 either disparity; low unused.
// - comma compare covers eight bits, eighth being inverse of seventh.
// - framer enable low freezes the current character boundary.
// - framer enable high applies the framer mode currently selected.
// - low-latency mode starts on first detection and stretches the clock.
// - a stretched character period grows by at most two bits.
// - character-rate output, framed characters within nine cycles.
// - other output rate, framed characters within fourteen cycles.
// - first multi-byte mode never shifts clock phase, moves data instead.
// - first multi-byte mode needs two hits within fifty bits, same offset.
// - alternate mode needs four consecutive hits on the same offset.
// - decoded data characters carry status 000.
// - decoded special characters carry status 001.
// - framing, invalid, disparity and resync use other status values.
// - odd parity is generated over each output character.
// - decoder mode low passes raw ten-bit characters to the output.
// - decoder mode mid maps specials with the primary column.
// - decoder mode high maps specials with the alternate column.
`timescale 1ns/100ps
`include "rxfd_regs.vh"
module rxfd_top (
  // clock and reset
  input wire clk,
  input wire rst,
  // deserialised bits, first received in bit 9, same clock
  input wire [9:0] rx_raw_in,
  // framer controls from pins
  input wire framer_enable_in,
  input wire [1:0] framing_pattern_select,
  input wire [1:0] framer_mode_select,
  input wire rx_output_clock_rate,
  // decoder control from pins
  input wire [1:0] decoder_mode_select,
  // output register
  output wire [9:0] rx_data_out,
  output wire [2:0] rx_status_code,
  output wire rx_parity,
  output wire rx_char_valid,
  // framer state
  output reg [3:0] rx_boundary_offset,
  output reg rx_framer_aligning
);

  // ----------------------------------------
  // low-latency framer states
  // ----------------------------------------
  localparam ST_HUNT = 2'b01;
  localparam ST_STRETCH = 2'b10;

  // ----------------------------------------
  // pin synchronisation and select resolving
  // ----------------------------------------
  wire [7:0] pin_s;
  wire fen;
  wire rate_half;
  wire [1:0] fchar;
  wire [1:0] fmode;
  wire [1:0] dmode;

  function [1:0] tri_res;
    input [1:0] v;
    // open pin floats to the middle level
    tri_res = (v == `RXFD_TRI_OPEN) ? `RXFD_TRI_MID : v;
  endfunction

  rxfd_pin_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({framer_enable_in, framing_pattern_select,
             framer_mode_select, decoder_mode_select,
             rx_output_clock_rate}),
    .pin_out(pin_s)
  );

  assign fen = pin_s[7];
  assign fchar = tri_res(pin_s[6:5]);
  assign fmode = tri_res(pin_s[4:3]);
  assign dmode = tri_res(pin_s[2:1]);
  assign rate_half = pin_s[0];

  // ----------------------------------------
  // bit history and pattern search
  // ----------------------------------------
  reg [19:0] hist;
  wire [9:0] hit;

  always @(posedge clk) begin
    if (rst)
      hist <= 20'h00000;
    else
      hist <= {hist[9:0], rx_raw_in};
  end

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_off
      wire [9:0] win;
      wire full_hit;
      wire comma_hit;
      assign win = hist[19-g -: 10];
      assign full_hit = (win == `RXFD_K285_NEG) ||
                        (win == `RXFD_K285_POS);
      // eight bits compared, not seven, to cut false framing
      assign comma_hit = (win[9:2] == `RXFD_COMMA_POS) ||
                         (win[9:2] == `RXFD_COMMA_NEG);
      // low select is reserved and never matches
      assign hit[g] = (fchar == `RXFD_TRI_HIGH) ? full_hit :
                      (fchar == `RXFD_TRI_MID) ? comma_hit :
                      1'b0;
    end
  endgenerate

  // lowest offset wins when more than one matches
  reg any_hit;
  reg [3:0] hit_off;
  integer k;

  always @* begin
    any_hit = |hit;
    hit_off = 4'h0;
    for (k = 9; k >= 0; k = k - 1) begin
      if (hit[k])
        hit_off = k[3:0];
    end
  end

  // ----------------------------------------
  // character at the current boundary
  // ----------------------------------------
  reg [9:0] cur_char;
  wire frame_at_cur;

  always @* begin
    cur_char = hist[(19 - rx_boundary_offset) -: 10];
  end

  assign frame_at_cur = hit[rx_boundary_offset];

  // ----------------------------------------
  // low-latency stretch step
  // ----------------------------------------
  reg [1:0] state;
  reg [3:0] ll_target;
  reg [3:0] ll_dist;
  reg [3:0] ll_step;
  reg [4:0] ll_sum;
  reg [3:0] ll_next_off;
  reg [3:0] ll_cnt;
  reg half_phase;
  wire ll_step_en;
  wire [3:0] ll_limit;

  always @* begin
    if (ll_target >= rx_boundary_offset)
      ll_dist = ll_target - rx_boundary_offset;
    else
      ll_dist = ll_target + `RXFD_CHAR_BITS - rx_boundary_offset;
    ll_step = (ll_dist > `RXFD_LL_MAX_STEP) ?
              `RXFD_LL_MAX_STEP : ll_dist;
    ll_sum = {1'b0, rx_boundary_offset} + {1'b0, ll_step};
    if (ll_sum >= {1'b0, `RXFD_CHAR_BITS})
      ll_next_off = ll_sum[3:0] - `RXFD_CHAR_BITS;
    else
      ll_next_off = ll_sum[3:0];
  end

  // half-rate output clock stretches on every other character
  assign ll_step_en = !rate_half || half_phase;
  assign ll_limit = rate_half ? `RXFD_LL_LAT_HALF : `RXFD_LL_LAT_CHAR;

  // ----------------------------------------
  // multi-byte framer trackers
  // ----------------------------------------
  reg mb_armed;
  reg [3:0] mb_off;
  reg [2:0] mb_age;
  reg [2:0] alt_cnt;
  reg [3:0] alt_off;
  reg resync;
  wire mb_confirm;
  wire alt_confirm;

  // second hit at most four characters later stays inside fifty bits
  assign mb_confirm = any_hit && mb_armed && (hit_off == mb_off) &&
                      (mb_age < `RXFD_MB_MAX_AGE);
  assign alt_confirm = any_hit && (alt_cnt != 3'h0) &&
                       (hit_off == alt_off) &&
                       (alt_cnt + 3'h1 == `RXFD_ALT_NEEDED);

  // ----------------------------------------
  // framer control
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_HUNT;
      rx_boundary_offset <= 4'h0;
      rx_framer_aligning <= 1'b0;
      ll_target <= 4'h0;
      ll_cnt <= 4'h0;
      half_phase <= 1'b0;
      mb_armed <= 1'b0;
      mb_off <= 4'h0;
      mb_age <= 3'h0;
      alt_cnt <= 3'h0;
      alt_off <= 4'h0;
      resync <= 1'b0;
    end else begin
      resync <= 1'b0;
      half_phase <= ~half_phase;
      if (!fen) begin
        // boundary frozen, partial searches dropped
        state <= ST_HUNT;
        rx_framer_aligning <= 1'b0;
        mb_armed <= 1'b0;
        alt_cnt <= 3'h0;
      end else begin
        case (fmode)
          `RXFD_TRI_LOW: begin
            mb_armed <= 1'b0;
            alt_cnt <= 3'h0;
            case (state)
              ST_HUNT: begin
                if (any_hit && hit_off != rx_boundary_offset) begin
                  ll_target <= hit_off;
                  ll_cnt <= 4'h0;
                  state <= ST_STRETCH;
                  rx_framer_aligning <= 1'b1;
                end
              end
              ST_STRETCH: begin
                ll_cnt <= ll_cnt + 4'h1;
                if (ll_dist == 4'h0 || ll_cnt + 4'h1 >= ll_limit) begin
                  state <= ST_HUNT;
                  rx_framer_aligning <= 1'b0;
                  resync <= 1'b1;
                end else if (ll_step_en) begin
                  rx_boundary_offset <= ll_next_off;
                end
              end
              default: begin
                state <= ST_HUNT;
                rx_framer_aligning <= 1'b0;
              end
            endcase
          end
          `RXFD_TRI_HIGH: begin
            state <= ST_HUNT;
            rx_framer_aligning <= 1'b0;
            mb_armed <= 1'b0;
            if (!any_hit) begin
              alt_cnt <= 3'h0;
            end else if (alt_confirm) begin
              // data realigned, clock phase left alone
              rx_boundary_offset <= hit_off;
              resync <= (hit_off != rx_boundary_offset);
              alt_cnt <= 3'h0;
            end else if (alt_cnt != 3'h0 && hit_off == alt_off) begin
              alt_cnt <= alt_cnt + 3'h1;
            end else begin
              alt_cnt <= 3'h1;
              alt_off <= hit_off;
            end
          end
          default: begin
            state <= ST_HUNT;
            rx_framer_aligning <= 1'b0;
            alt_cnt <= 3'h0;
            if (mb_confirm) begin
              rx_boundary_offset <= hit_off;
              resync <= (hit_off != rx_boundary_offset);
              mb_age <= 3'h0;
            end else if (any_hit) begin
              mb_armed <= 1'b1;
              mb_off <= hit_off;
              mb_age <= 3'h0;
            end else if (mb_armed) begin
              if (mb_age >= `RXFD_MB_MAX_AGE)
                mb_armed <= 1'b0;
              else
                mb_age <= mb_age + 3'h1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // decoder and output register
  // ----------------------------------------
  // a stretched character period yields no character
  wire char_valid;
  assign char_valid = (state != ST_STRETCH);

  rxfd_decoder u_decoder (
    .clk(clk),
    .rst(rst),
    .in_valid(char_valid),
    .in_char(cur_char),
    .in_framing(frame_at_cur),
    .in_resync(resync),
    .dec_mode(dmode),
    .out_valid(rx_char_valid),
    .out_data(rx_data_out),
    .out_status(rx_status_code),
    .out_parity(rx_parity)
  );

endmodule // rxfd_top

// [verification/rxfd_props.sv]
// concurrent checks on the framer and decoder top-level ports
`timescale 1ns/100ps
module rxfd_props (
  // clock and reset
  input wire clk,
  input wire rst,
  // controls
  input wire framer_enable_in,
  input wire [1:0] framing_pattern_select,
  input wire [1:0] framer_mode_select,
  input wire rx_output_clock_rate,
  input wire [1:0] decoder_mode_select,
  // outputs
  input wire [9:0] rx_data_out,
  input wire [2:0] rx_status_code,
  input wire rx_parity,
  input wire rx_char_valid,
  input wire [3:0] rx_boundary_offset,
  input wire rx_framer_aligning
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // -----
  // assertions
  // -----
  a_parity_odd:
    assert property (^{rx_data_out, rx_parity})
    else $error("output parity is even");
  a_fen_freeze:
    assert property ((!framer_enable_in)[*5] |=> $stable(rx_boundary_offset))
    else $error("boundary moved with framer off");
  a_lowsel_nomatch:
    assert property ((framing_pattern_select == 2'h0)[*5]
      |=> $stable(rx_boundary_offset))
    else $error("boundary moved with reserved pattern select");
  a_step_max:
    assert property (rx_framer_aligning |=> (((10 + rx_boundary_offset
      - $past(rx_boundary_offset)) % 10) inside {[0:2], [8:9]}))
    else $error("stretch step above two bits");
  a_multi_no_stretch:
    assert property ((framer_mode_select != 2'h0)[*4] |-> !rx_framer_aligning)
    else $error("clock stretched in multi-byte mode");
  a_ll_char_bound:
    assert property ($rose(rx_framer_aligning) && !rx_output_clock_rate
      |-> ##[1:9] !rx_framer_aligning)
    else $error("low-latency alignment too long at char rate");
  a_ll_half_bound:
    assert property ($rose(rx_framer_aligning) && rx_output_clock_rate
      |-> ##[1:14] !rx_framer_aligning)
    else $error("low-latency alignment too long at half rate");
  a_bypass_status:
    assert property ((decoder_mode_select == 2'h0)[*6] ##0 rx_char_valid
      |-> rx_status_code == 3'h0)
    else $error("status not zero in bypass");
  a_valid_stretch:
    assert property (rx_framer_aligning && $past(rx_framer_aligning)
      |-> !rx_char_valid)
    else $error("character loaded during stretch");

  c_align: cover property ($rose(rx_framer_aligning));
  c_special: cover property (rx_status_code == 3'h1);
  c_resync: cover property (rx_status_code == 3'h3);
  c_alt_move: cover property ($changed(rx_boundary_offset)
    && framer_mode_select == 2'h2);
endmodule // rxfd_props

bind rxfd_top rxfd_props u_props (.clk(clk), .rst(rst),
  .framer_enable_in(framer_enable_in),
  .framing_pattern_select(framing_pattern_select),
  .framer_mode_select(framer_mode_select),
  .rx_output_clock_rate(rx_output_clock_rate),
  .decoder_mode_select(decoder_mode_select), .rx_data_out(rx_data_out),
  .rx_status_code(rx_status_code), .rx_parity(rx_parity),
  .rx_char_valid(rx_char_valid), .rx_boundary_offset(rx_boundary_offset),
  .rx_framer_aligning(rx_framer_aligning));

// [verification/rxfd_tx_model.sv]
// remote transmitter: character stream seen at a chosen bit slip
`timescale 1ns/100ps
module rxfd_tx_model (
  // clock
  input wire clk,
  // character to send and bit slip 0..9
  input wire [9:0] char_in,
  input wire [3:0] slip,
  // deserialised word, first bit in bit 9
  output wire [9:0] raw_out
);
  reg [19:0] hist = 20'h00000;
  always @(posedge clk) begin
    hist <= {hist[9:0], char_in};
  end
  // slip moves the word boundary away from the character boundary
  assign raw_out = hist[19 - slip -: 10];
endmodule // rxfd_tx_model

// [verification/test_rxfd_top.sv]
// self-checking bench for the receive framer and decoder
`timescale 1ns/100ps
module test_rxfd_top;
  typedef struct packed {
    logic [1:0] dm;
    logic [9:0] ch;
    logic fl;
    logic [9:0] ed;
    logic [9:0] mk;
    logic [2:0] es;
  } rxfd_row_t;
  logic clk, rst, fen, rate, vld, par, algn, al;
  logic [1:0] fchar, fmode, dmode;
  logic [9:0] raw, dout, tx_char;
  logic [2:0] st;
  logic [3:0] off, slip;
  rxfd_row_t rows [0:8];
  int fails = 0;
  int checks = 0;
  int r;

  rxfd_tx_model u_tx (.clk(clk), .char_in(tx_char), .slip(slip),
    .raw_out(raw));
  rxfd_top DUT (.clk(clk), .rst(rst), .rx_raw_in(raw),
    .framer_enable_in(fen), .framing_pattern_select(fchar),
    .framer_mode_select(fmode), .rx_output_clock_rate(rate),
    .decoder_mode_select(dmode), .rx_data_out(dout), .rx_status_code(st),
    .rx_parity(par), .rx_char_valid(vld), .rx_boundary_offset(off),
    .rx_framer_aligning(algn));

  always #25 clk = ~clk;

  // -----
  // tasks
  // -----
  task chk_vec(input string nm, input logic [9:0] ex, input logic [9:0] got,
    input logic [9:0] mk);
    checks++;
    if ((got & mk) !== (ex & mk)) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task chk_bit(input string nm, input logic ex, input logic got);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, ex, got);
    end
  endtask

  task send(input logic [9:0] c, input int n, input logic fl);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      tx_char = (fl && i[0]) ? ~c : c;
    end
  endtask

  // neutral filler keeps running while the boundary settles
  task wait_off(input logic [3:0] ex, input int lim);
    int i;
    al = 1'b0;
    for (i = 0; i < lim && off !== ex; i++) begin
      @(posedge clk);
      #1;
      tx_char = 10'h319;
      al = al | (algn === 1'b1);
    end
    chk_vec("offset", {6'h00, ex}, {6'h00, off}, 10'h3FF);
  endtask

  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // about 250 cycles of tests, sixteen times that before giving up
  initial begin
    #200000;
    fails++;
    end_sim;
  end

  // -----
  // sequence
  // -----
  initial begin
    // flipped rows alternate both disparities; even lengths keep it negative
    rows[0] = '{2'h0, 10'h319, 1'b0, 10'h319, 10'h3FF, 3'h0};
    rows[1] = '{2'h0, 10'h000, 1'b0, 10'h000, 10'h3FF, 3'h0};
    rows[2] = '{2'h1, 10'h319, 1'b0, 10'h023, 10'h3FF, 3'h0};
    rows[3] = '{2'h3, 10'h295, 1'b0, 10'h045, 10'h3FF, 3'h0};
    rows[4] = '{2'h2, 10'h295, 1'b0, 10'h045, 10'h3FF, 3'h0};
    // neutral special keeps one form; flipping it breaks disparity
    rows[5] = '{2'h1, 10'h0F4, 1'b0, 10'h000, 10'h000, 3'h1};
    rows[6] = '{2'h2, 10'h0F4, 1'b0, 10'h000, 10'h000, 3'h1};
    rows[7] = '{2'h1, 10'h0FA, 1'b1, 10'h000, 10'h000, 3'h2};
    rows[8] = '{2'h1, 10'h000, 1'b0, 10'h000, 10'h000, 3'h6};
    clk = 1'b0;
    rst = 1'b1;
    fen = 1'b0;
    fchar = 2'h2;
    fmode = 2'h2;
    rate = 1'b0;
    dmode = 2'h0;
    tx_char = 10'h319;
    slip = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    chk_vec("reset data", 10'h000, dout, 10'h3FF);
    chk_vec("reset offset", 10'h000, {6'h00, off}, 10'h3FF);
    chk_bit("reset parity", 1'b1, par);
    chk_bit("reset valid", 1'b0, vld);
    $display("test reset done");
    rst = 1'b0;
    // output clock rate pin stays low, character rate, through the decode rows
    for (r = 0; r < 9; r++) begin
      dmode = rows[r].dm;
      send(rows[r].ch, 8, rows[r].fl);
      chk_vec("data", rows[r].ed, dout, rows[r].mk);
      chk_vec("status", {7'h00, rows[r].es}, {7'h00, st}, 10'h3FF);
      chk_bit("valid", 1'b1, vld);
      if (rows[r].mk == 10'h3FF)
        chk_bit("parity", ~^rows[r].ed, par);
    end
    $display("test decode rows done");
    slip = 4'h3;
    send(10'h0FA, 16, 1'b1);
    chk_vec("offset", 10'h000, {6'h00, off}, 10'h3FF);
    fen = 1'b1;
    fchar = 2'h0;
    send(10'h0FA, 16, 1'b1);
    chk_vec("offset", 10'h000, {6'h00, off}, 10'h3FF);
    $display("test framer refusals done");
    fchar = 2'h2;
    send(10'h319, 6, 1'b0);
    send(10'h0FA, 3, 1'b1);
    send(10'h319, 8, 1'b0);
    chk_vec("offset", 10'h000, {6'h00, off}, 10'h3FF);
    send(10'h0FA, 4, 1'b1);
    wait_off(4'h7, 12);
    chk_bit("aligning", 1'b0, al);
    $display("test alternate mode done");
    fmode = 2'h3;
    fchar = 2'h1;
    slip = 4'h5;
    send(10'h319, 6, 1'b0);
    send(10'h0FA, 1, 1'b0);
    send(10'h319, 8, 1'b0);
    send(10'h0FA, 1, 1'b0);
    send(10'h319, 8, 1'b0);
    chk_vec("offset", 10'h007, {6'h00, off}, 10'h3FF);
    send(10'h0FA, 1, 1'b0);
    send(10'h319, 1, 1'b0);
    send(10'h0FA, 1, 1'b0);
    wait_off(4'h5, 10);
    chk_bit("aligning", 1'b0, al);
    al = 1'b0;
    repeat (4) begin
      al = al | (st === 3'h3);
      @(posedge clk);
      #1;
    end
    chk_bit("resync seen", 1'b1, al);
    $display("test multi-byte mode done");
    fmode = 2'h0;
    fchar = 2'h2;
    slip = 4'h8;
    send(10'h319, 6, 1'b0);
    send(10'h0FA, 1, 1'b0);
    wait_off(4'h2, 20);
    chk_bit("aligning", 1'b1, al);
    rate = 1'b1;
    slip = 4'h1;
    send(10'h319, 6, 1'b0);
    send(10'h0FA, 1, 1'b0);
    wait_off(4'h9, 30);
    chk_bit("aligning", 1'b1, al);
    $display("test low-latency mode done");
    end_sim;
  end
endmodule // test_rxfd_top
